// ### unpack_consts.vh
`ifndef UNPACK_CONSTS_VH
`define UNPACK_CONSTS_VH
`define PACK_NONE      2'h0
`define PACK_TWO       2'h1
`define PACK_THREE     2'h2
`define PACK_SIX       2'h3
`define WORDS_NONE     4'h1
`define WORDS_TWO      4'h2
`define WORDS_THREE    4'h4
`define WORDS_SIX      4'h8
`define SEG_WORDS_TWO  24'h100000
`define SEG_WORDS_THR  24'h080000
`define SEG_WORDS_SIX  24'h040000
`define BANK_ZERO      2'h0
`endif

// ### instruction_unpacking_translator.v
`timescale 1ns/10ps
`default_nettype none
`include "unpack_consts.vh"
module instruction_unpacking_translator #(
   parameter PAGE_BITS = 8
) (
   input  wire        i_core_clk,
   input  wire        i_arst_n,
   input  wire [1:0]  i_instruction_packing_select,
   input  wire [23:0] i_seg_start,
   input  wire        i_fetch_req,
   input  wire [23:0] i_fetch_addr,
   output reg         o_fetch_stall,
   output reg         o_opcode_valid,
   output reg  [47:0] o_opcode,
   output reg         o_seg_overflow,
   output reg  [23:0] o_page_span,
   output reg         o_mem_req,
   output reg  [26:0] o_mem_addr,
   output reg  [1:0]  o_mem_bank,
   input  wire        i_mem_ack,
   input  wire [47:0] i_mem_rdata
);
   localparam ST_IDLE = 1'b0;
   localparam ST_READ = 1'b1;

   reg        state;
   reg [1:0]  mode;
   reg [2:0]  idx;
   reg [47:0] acc;

   // Next values of the fetch sequencer and outputs
   reg        next_state;
   reg [1:0]  next_mode;
   reg [2:0]  next_idx;
   reg [47:0] next_acc;
   reg        next_fetch_stall;
   reg        next_opcode_valid;
   reg [47:0] next_opcode;
   reg        next_seg_overflow;
   reg [23:0] next_page_span;
   reg        next_mem_req;
   reg [26:0] next_mem_addr;
   reg [1:0]  next_mem_bank;

   // Reads per instruction for a mode (including the unused fourth, or seventh and eighth)
   function [3:0] words_for;
      input [1:0] m;
      begin
         case (m)
            `PACK_TWO:   words_for = `WORDS_TWO;
            `PACK_THREE: words_for = `WORDS_THREE;
            `PACK_SIX:   words_for = `WORDS_SIX;
            default:     words_for = `WORDS_NONE;
         endcase
      end
   endfunction

   // Right shift of the page size for a mode
   function [4:0] span_shift;
      input [1:0] m;
      begin
         case (m)
            `PACK_TWO:   span_shift = 5'h1;
            `PACK_THREE: span_shift = 5'h2;
            `PACK_SIX:   span_shift = 5'h3;
            default:     span_shift = 5'h0;
         endcase
      end
   endfunction

   // First physical address: k*L - (k-1)*S
   function [26:0] first_addr;
      input [1:0]  m;
      input [23:0] l;
      input [23:0] s;
      begin
         case (m)
            `PACK_TWO:   first_addr = {2'h0, l, 1'b0} - {3'h0, s};
            `PACK_THREE: first_addr = {1'b0, l, 2'h0} - {2'h0, s, 1'b0} - {3'h0, s};
            `PACK_SIX:   first_addr = {l, 3'h0} - {s, 3'h0} + {3'h0, s};
            default:     first_addr = {3'h0, l};
         endcase
      end
   endfunction

   // Offset beyond the longest segment of a packed mode
   function seg_over;
      input [1:0]  m;
      input [23:0] off;
      begin
         case (m)
            `PACK_TWO:   seg_over = off >= `SEG_WORDS_TWO;
            `PACK_THREE: seg_over = off >= `SEG_WORDS_THR;
            `PACK_SIX:   seg_over = off >= `SEG_WORDS_SIX;
            default:     seg_over = 1'b0;
         endcase
      end
   endfunction

   // Lay one external word into its ascending lanes; rest is held
   function [47:0] place_word;
      input [1:0]  m;
      input [2:0]  i;
      input [47:0] part;
      input [47:0] word;
      begin
         case (m)
            `PACK_TWO: begin
               if (i == 3'h0)
                  place_word = {part[47:32], word[31:0]};
               else
                  place_word = {word[15:0], part[31:0]};
            end
            `PACK_THREE: begin
               case (i)
                  3'h0:    place_word = {part[47:16], word[15:0]};
                  3'h1:    place_word = {part[47:32], word[15:0], part[15:0]};
                  3'h2:    place_word = {word[15:0], part[31:0]};
                  default: place_word = part; // Fourth word is padding
               endcase
            end
            `PACK_SIX: begin
               if (i < 3'h6)
                  place_word = part | ({40'h0, word[7:0]} << {i, 3'h0});
               else
                  place_word = part; // Last two bytes are padding
            end
            default: place_word = word;
         endcase
      end
   endfunction

   // Page span, segment offset and word placement
   localparam [23:0] PAGE_SIZE = 24'h1 << PAGE_BITS;
   wire [3:0]  nwords   = words_for(mode);
   wire [23:0] seg_off  = i_fetch_addr - i_seg_start;
   wire        last_ack = ({1'b0, idx} == nwords - 4'h1);
   wire [47:0] merged   = place_word(mode, idx, acc, i_mem_rdata);

   // Sequencer decisions for the coming edge
   always @* begin
      next_state        = state;
      next_mode         = mode;
      next_idx          = idx;
      next_acc          = acc;
      next_fetch_stall  = o_fetch_stall;
      next_opcode_valid = 1'b0;
      next_opcode       = o_opcode;
      next_seg_overflow = o_seg_overflow;
      next_page_span    = PAGE_SIZE >> span_shift(i_instruction_packing_select);
      next_mem_req      = o_mem_req;
      next_mem_addr     = o_mem_addr;
      next_mem_bank     = `BANK_ZERO;
      case (state)
         ST_IDLE: begin
            if (i_fetch_req) begin
               next_mode         = i_instruction_packing_select;
               next_idx          = 3'h0;
               next_acc          = 48'h0;
               next_state        = ST_READ;
               next_fetch_stall  = 1'b1;
               next_mem_req      = 1'b1;
               next_mem_addr     = first_addr(i_instruction_packing_select, i_fetch_addr, i_seg_start);
               next_seg_overflow = seg_over(i_instruction_packing_select, seg_off);
            end
         end
         ST_READ: begin
            if (i_mem_ack) begin
               next_acc = merged;
               if (last_ack) begin
                  next_state        = ST_IDLE;
                  next_mem_req      = 1'b0;
                  next_fetch_stall  = 1'b0;
                  next_opcode_valid = 1'b1;
                  next_opcode       = merged;
               end else begin
                  next_idx      = idx + 3'h1;
                  next_mem_addr = o_mem_addr + 27'h1;
               end
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // Sequencer state registers
   always @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= ST_IDLE;
         mode  <= `PACK_NONE;
         idx   <= 3'h0;
         acc   <= 48'h0;
      end else begin
         state <= next_state;
         mode  <= next_mode;
         idx   <= next_idx;
         acc   <= next_acc;
      end
   end

   // Handshake outputs toward sequencer and memory
   always @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_fetch_stall  <= 1'b0;
         o_opcode_valid <= 1'b0;
         o_mem_req      <= 1'b0;
         o_mem_addr     <= 27'h0;
         o_mem_bank     <= 2'h0;
      end else begin
         o_fetch_stall  <= next_fetch_stall;
         o_opcode_valid <= next_opcode_valid;
         o_mem_req      <= next_mem_req;
         o_mem_addr     <= next_mem_addr;
         o_mem_bank     <= next_mem_bank;
      end
   end

   // Opcode and status outputs
   always @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_opcode       <= 48'h0;
         o_seg_overflow <= 1'b0;
         o_page_span    <= 24'h0;
      end else begin
         o_opcode       <= next_opcode;
         o_seg_overflow <= next_seg_overflow;
         o_page_span    <= next_page_span;
      end
   end
endmodule // instruction_unpacking_translator
`default_nettype wire

// ### iut_chk_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module iut_chk #(parameter PAGE_BITS = 8) (
   input wire logic        i_core_clk,
   input wire logic        i_arst_n,
   input wire logic        i_fetch_req,
   input wire logic        o_fetch_stall,
   input wire logic        o_opcode_valid,
   input wire logic        o_mem_req,
   input wire logic        i_mem_ack,
   input wire logic [1:0]  i_instruction_packing_select,
   input wire logic [1:0]  o_mem_bank,
   input wire logic [23:0] i_seg_start,
   input wire logic [23:0] i_fetch_addr,
   input wire logic [23:0] o_page_span,
   input wire logic [26:0] o_mem_addr
);
   wire [1:0]  m = i_instruction_packing_select;
   logic [3:0] acks;
   // Acks taken in the current read group
   always_ff @(posedge i_core_clk or negedge i_arst_n)
      if (!i_arst_n) acks <= 4'h0;
      else acks <= o_opcode_valid ? 4'h0 : acks + {3'h0, o_mem_req & i_mem_ack};
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_arst_n);
   a_bank_zero: assert property (o_mem_bank == 2'h0) else $error("bank not zero");
   a_req_stall: assert property (o_mem_req == o_fetch_stall) else $error("stall off");
   a_valid_pulse: assert property (o_opcode_valid |-> !o_fetch_stall ##1 !o_opcode_valid) else $error("pulse");
   a_take_idle: assert property (i_fetch_req & !o_fetch_stall & !o_opcode_valid |=> o_fetch_stall)
      else $error("request lost");
   a_read_count: assert property (o_opcode_valid |-> acks == 4'h1 << m) else $error("read count");
   a_first_addr: assert property ($rose(o_mem_req) |->
      o_mem_addr == ({3'h0, $past(i_fetch_addr)} << $past(m)) - {3'h0, $past(i_seg_start)} * ((27'h1 << $past(m)) - 27'h1))
      else $error("first address");
   a_addr_step: assert property (o_mem_req & i_mem_ack ##1 o_mem_req |-> o_mem_addr == $past(o_mem_addr) + 27'h1)
      else $error("address step");
   a_page_span: assert property ($past(i_arst_n) && m == $past(m) |-> o_page_span == (24'h1 << PAGE_BITS) >> m)
      else $error("page span");
   c_none: cover property (o_opcode_valid && m == 2'h0);
   c_two: cover property (o_opcode_valid && m == 2'h1);
   c_three: cover property (o_opcode_valid && m == 2'h2);
   c_six: cover property (o_opcode_valid && m == 2'h3);
endmodule // iut_chk
bind instruction_unpacking_translator iut_chk #(.PAGE_BITS(PAGE_BITS)) chk_u (
   .i_core_clk(i_core_clk),
   .i_arst_n(i_arst_n),
   .i_fetch_req(i_fetch_req),
   .o_fetch_stall(o_fetch_stall),
   .o_opcode_valid(o_opcode_valid),
   .o_mem_req(o_mem_req),
   .i_mem_ack(i_mem_ack),
   .i_instruction_packing_select(i_instruction_packing_select),
   .o_mem_bank(o_mem_bank),
   .i_seg_start(i_seg_start),
   .i_fetch_addr(i_fetch_addr),
   .o_page_span(o_page_span),
   .o_mem_addr(o_mem_addr)
);
`default_nettype wire

// ### iut_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module iut_mem_model (
   input wire logic        i_core_clk,
   input wire logic        i_slow,
   input wire logic        i_mem_req,
   input wire logic [26:0] i_mem_addr,
   output logic            o_mem_ack,
   output logic [47:0]     o_mem_rdata
);
   logic gate = 1'b1;
   wire [47:0] w = {i_mem_addr[23:0] ^ 24'h5a5a5a, i_mem_addr[23:0]};
   // Random wait states when slow
   always @(posedge i_core_clk) gate <= #1 !i_slow || $urandom % 2;
   assign o_mem_ack = i_mem_req && gate;
   assign o_mem_rdata = o_mem_ack ? w : ~w; // Garbage without ack
endmodule // iut_mem_model
`default_nettype wire

// ### instruction_unpacking_translator_test.sv
`timescale 1ns/10ps
`default_nettype none
module instruction_unpacking_translator_test;
   logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, slow = 1'b0, ack, stall, valid, ovf, mreq;
   logic [1:0]  sel = 2'h0, bank;
   logic [23:0] seg = 24'h0, addr = 24'h0, span;
   logic [47:0] op, rdata;
   logic [26:0] maddr;
   int          fails = 0, comparisons = 0;
   instruction_unpacking_translator #(.PAGE_BITS(8)) dut_u (.i_core_clk(clk), .i_arst_n(rst_n),
      .i_instruction_packing_select(sel), .i_seg_start(seg), .i_fetch_req(req), .i_fetch_addr(addr),
      .o_fetch_stall(stall), .o_opcode_valid(valid), .o_opcode(op), .o_seg_overflow(ovf), .o_page_span(span),
      .o_mem_req(mreq), .o_mem_addr(maddr), .o_mem_bank(bank), .i_mem_ack(ack), .i_mem_rdata(rdata));
   iut_mem_model mem_u (.i_core_clk(clk), .i_slow(slow), .i_mem_req(mreq), .i_mem_addr(maddr),
      .o_mem_ack(ack), .o_mem_rdata(rdata));
   initial forever #50 clk = ~clk;
   // Opcode assembled from packed words, low part first
   function automatic logic [47:0] expect_op(logic [1:0] m, logic [23:0] s, l);
      logic [26:0] p, a;
      logic [47:0] e, wd;
      int          w;
      p = ({3'h0, l} << m) - {3'h0, s} * ((27'h1 << m) - 27'h1);
      w = (m == 2'h0) ? 48 : 64 >> m;
      for (int b = 0; b < 48; b++) begin
         a = p + 27'(b / w);
         wd = {a[23:0] ^ 24'h5a5a5a, a[23:0]};
         e[b] = wd[b % w];
      end
      return e;
   endfunction
   // Longest segment per packed mode, in logical words
   function automatic logic [23:0] seg_limit(logic [1:0] m);
      return (m == 2'h1) ? 24'h100000 : (m == 2'h2) ? 24'h080000 : 24'h040000;
   endfunction
   task automatic chk(string n, logic [47:0] x, g);
      comparisons++;
      if (g !== x) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic final_report();
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // One fetch; packing is set along with the request and held
   task automatic fetch(logic [1:0] m, logic [23:0] s, l);
      int t;
      @(posedge clk) #1;
      {sel, seg, addr, req, t} = {m, s, l, 1'b1, 32'h0};
      while (valid !== 1'b1 && t < 200) begin
         @(posedge clk) #1;
         t++;
         if (stall === 1'b1) req = 1'b0;
      end
      if (valid !== 1'b1) begin
         fails++;
         final_report();
      end
      chk("opcode", expect_op(m, s, l), op);
      chk("overflow", {47'h0, m != 2'h0 && l - s >= seg_limit(m)}, {47'h0, ovf});
      chk("page span", {24'h0, 24'h000100 >> m}, {24'h0, span});
      chk("stall", 48'h0, {47'h0, stall});
   endtask
   initial begin
      void'($urandom(54));
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      for (int n = 0; n < 40; n++) begin
         logic [23:0] s, d;
         s = 24'($urandom);
         d = (n % 5 == 4) ? 24'h200000 | 24'($urandom % 4096) : 24'($urandom % 256);
         slow = n[1];
         fetch(n < 4 ? 2'(n) : 2'($urandom), s, s + d);
      end
      // Segment limits hit exactly, just inside and at the edge
      for (int k = 1; k < 4; k++) begin
         fetch(2'(k), 24'h123456, 24'h123456 + seg_limit(2'(k)) - 24'h1);
         fetch(2'(k), 24'h123456, 24'h123456 + seg_limit(2'(k)));
      end
      final_report();
   end
endmodule // instruction_unpacking_translator_test
`default_nettype wire
